// >>> common/nvm_timebase_pkg.sv
// Constants, field positions and types for the EEPROM program/erase timing block.
// Assumes a single clock domain fed by the oscillator clock input.
package nvm_timebase_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DIV_WIDTH = 10;
  localparam int DIV_HIGH_WIDTH = 2;
  localparam int DIV_LOW_WIDTH = 8;
  localparam int ADDR_WIDTH = 11;
  localparam int TICK_WIDTH = 16;
  localparam int WCOUNT_WIDTH = 4;

  // ----------------------------------------------------------------
  // Program control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_PULSE_BIT = 0;
  localparam int CTRL_LATCH_BIT = 1;
  localparam int CTRL_ERASE_BIT = 2;
  localparam int CTRL_AUTO_BIT = 5;
  localparam logic [7:0] CTRL_WRITABLE_MASK = 8'h27;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [DIV_HIGH_WIDTH-1:0] DIV_HIGH_RESET = 2'h0;
  localparam logic [DIV_LOW_WIDTH-1:0] DIV_LOW_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing, in time base ticks, and selective write limit
  // ----------------------------------------------------------------
  localparam logic [TICK_WIDTH-1:0] PROGRAM_TICKS = 16'h0010;
  localparam logic [TICK_WIDTH-1:0] ERASE_TICKS = 16'h0020;
  localparam logic [WCOUNT_WIDTH-1:0] MAX_SELECTIVE_WRITES = 4'h8;

  // ----------------------------------------------------------------
  // Pulse state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_AUTO = 3'b010,
    ST_MANUAL = 3'b100
  } pulse_state_type;
endpackage

// >>> core/timebase_divider.sv
// Programmable time base divider: one tick every div_value+1 clocks while run is high.
// Assumes its clock is the oscillator clock, independent of bus clock settings.
module timebase_divider
  import nvm_timebase_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  input wire logic [DIV_WIDTH-1:0] div_value,
  output logic tick
);
  logic [DIV_WIDTH-1:0] count;
  logic [DIV_WIDTH-1:0] next_count;
  logic next_tick;

  // Restart from the full ratio whenever idle, so every operation starts on a whole period
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (!run) begin
      next_count = div_value;
    end else if (count == '0) begin
      next_count = div_value;
      next_tick = 1'b1;
    end else begin
      next_count = DIV_WIDTH'(count - 1'b1);
    end
  end

  // Divider state registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule

// >>> core/eeprom_program_timebase_ctrl.sv
// EEPROM program/erase timing control: divider registers, program control, pulse timing.
// Assumes core_clk is the oscillator clock input and shadow_word is stable from reset on.
//
// How it works
// - Divider clocked from oscillator clock, not bus.
// - Ten-bit ratio split over high/low registers.
// - Divider registers reload from shadow word after reset.
// - Control bit 5 enables automatic timing.
// - Hardware clears pulse bit when automatic operation completes.
// - Up to eight writes per location between erases; only the last location written is counted, any erase clears it.
module eeprom_program_timebase_ctrl
  import nvm_timebase_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [DIV_WIDTH-1:0] shadow_word,
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_wdata,
  input wire logic div_high_write,
  input wire logic [DIV_HIGH_WIDTH-1:0] div_high_wdata,
  input wire logic div_low_write,
  input wire logic [DIV_LOW_WIDTH-1:0] div_low_wdata,
  input wire logic [ADDR_WIDTH-1:0] target_addr,
  output logic [7:0] nvm_program_control,
  output logic [DIV_HIGH_WIDTH-1:0] nvm_timebase_div_high,
  output logic [DIV_LOW_WIDTH-1:0] nvm_timebase_div_low,
  output logic hv_enable,
  output logic op_done,
  output logic write_refused,
  output logic [WCOUNT_WIDTH-1:0] write_count
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Length of the operation in time base ticks
  function automatic logic [TICK_WIDTH-1:0] op_ticks(input logic erase_sel);
    op_ticks = erase_sel ? ERASE_TICKS : PROGRAM_TICKS;
  endfunction

  pulse_state_type state;
  pulse_state_type next_state;
  logic shadow_loaded;
  logic next_shadow_loaded;
  logic [DIV_HIGH_WIDTH-1:0] next_div_high;
  logic [DIV_LOW_WIDTH-1:0] next_div_low;
  logic [7:0] next_ctrl;
  logic [TICK_WIDTH-1:0] tick_count;
  logic [TICK_WIDTH-1:0] next_tick_count;
  logic [ADDR_WIDTH-1:0] last_addr;
  logic [ADDR_WIDTH-1:0] next_last_addr;
  logic [WCOUNT_WIDTH-1:0] next_write_count;
  logic next_hv_enable;
  logic next_op_done;
  logic next_write_refused;
  logic tick;
  logic [7:0] ctrl_new;
  logic start_req;
  logic same_loc;
  logic limit_hit;
  logic auto_finish;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // Runs only during an automatic pulse; the clock is the oscillator, never the bus clock
  timebase_divider u_divider (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .run(state == ST_AUTO),
    .div_value({nvm_timebase_div_high, nvm_timebase_div_low}),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Divider registers
  // ----------------------------------------------------------------
  // Reset clears them to constants; the first enabled edge copies the shadow word in.
  // Writes are held off while a pulse runs so the ratio cannot shift mid-operation.
  always_comb begin
    next_shadow_loaded = 1'b1;
    next_div_high = nvm_timebase_div_high;
    next_div_low = nvm_timebase_div_low;
    if (!shadow_loaded) begin
      next_div_high = shadow_word[DIV_WIDTH-1:DIV_LOW_WIDTH];
      next_div_low = shadow_word[DIV_LOW_WIDTH-1:0];
    end else if (state == ST_IDLE) begin
      if (div_high_write) begin
        next_div_high = div_high_wdata;
      end
      if (div_low_write) begin
        next_div_low = div_low_wdata;
      end
    end
  end

  // Divider register flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shadow_loaded <= 1'b0;
      nvm_timebase_div_high <= DIV_HIGH_RESET;
      nvm_timebase_div_low <= DIV_LOW_RESET;
    end else if (ce) begin
      shadow_loaded <= next_shadow_loaded;
      nvm_timebase_div_high <= next_div_high;
      nvm_timebase_div_low <= next_div_low;
    end
  end

  // ----------------------------------------------------------------
  // Program control and pulse sequencing
  // ----------------------------------------------------------------
  assign ctrl_new = ctrl_wdata & CTRL_WRITABLE_MASK;
  assign start_req = ctrl_write && ctrl_new[CTRL_PULSE_BIT];
  assign same_loc = (target_addr == last_addr) && (write_count != '0);
  assign limit_hit = !ctrl_new[CTRL_ERASE_BIT] && same_loc && (write_count == MAX_SELECTIVE_WRITES);
  assign auto_finish = tick && (tick_count == TICK_WIDTH'(op_ticks(nvm_program_control[CTRL_ERASE_BIT]) - 1'b1));

  // Only the pulse bit may change while busy; a software clear aborts an automatic pulse
  always_comb begin
    next_state = state;
    next_ctrl = nvm_program_control;
    next_tick_count = tick_count;
    next_last_addr = last_addr;
    next_write_count = write_count;
    next_op_done = 1'b0;
    next_write_refused = 1'b0;
    case (state)
      ST_IDLE: begin
        if (ctrl_write) begin
          next_ctrl = ctrl_new;
          if (start_req && limit_hit) begin
            next_ctrl[CTRL_PULSE_BIT] = 1'b0;
            next_write_refused = 1'b1;
          end else if (start_req) begin
            next_state = ctrl_new[CTRL_AUTO_BIT] ? ST_AUTO : ST_MANUAL;
            next_tick_count = '0;
            next_last_addr = target_addr;
            if (ctrl_new[CTRL_ERASE_BIT]) begin
              next_write_count = '0;
            end else if (same_loc) begin
              next_write_count = WCOUNT_WIDTH'(write_count + 1'b1);
            end else begin
              next_write_count = 4'h1;
            end
          end
        end
      end
      ST_AUTO: begin
        if (ctrl_write && !ctrl_wdata[CTRL_PULSE_BIT]) begin
          next_ctrl[CTRL_PULSE_BIT] = 1'b0;
          next_state = ST_IDLE;
        end else if (auto_finish) begin
          next_ctrl[CTRL_PULSE_BIT] = 1'b0;
          next_op_done = 1'b1;
          next_state = ST_IDLE;
          next_tick_count = '0;
        end else if (tick) begin
          next_tick_count = TICK_WIDTH'(tick_count + 1'b1);
        end
      end
      ST_MANUAL: begin
        // Software owns the duration here, so it must honour the minimum itself
        if (ctrl_write && !ctrl_wdata[CTRL_PULSE_BIT]) begin
          next_ctrl[CTRL_PULSE_BIT] = 1'b0;
          next_op_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_ctrl[CTRL_PULSE_BIT] = 1'b0;
      end
    endcase
    next_hv_enable = (next_state != ST_IDLE);
  end

  // Sequencer flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      nvm_program_control <= CTRL_RESET;
      tick_count <= '0;
      last_addr <= '0;
      write_count <= '0;
      hv_enable <= 1'b0;
      op_done <= 1'b0;
      write_refused <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      nvm_program_control <= next_ctrl;
      tick_count <= next_tick_count;
      last_addr <= next_last_addr;
      write_count <= next_write_count;
      hv_enable <= next_hv_enable;
      op_done <= next_op_done;
      write_refused <= next_write_refused;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_shadow_reload;
    $rose(shadow_loaded) |-> {nvm_timebase_div_high, nvm_timebase_div_low} == $past(shadow_word);
  endproperty
  a_shadow_reload: assert property (p_shadow_reload) else $error("divider not reloaded from shadow word");

  property p_div_high_write;
    ce && shadow_loaded && state == ST_IDLE && div_high_write |=> nvm_timebase_div_high == $past(div_high_wdata);
  endproperty
  a_div_high_write: assert property (p_div_high_write) else $error("high divider write lost");

  property p_auto_select;
    ce && state == ST_IDLE && start_req && !limit_hit |=> state == ($past(ctrl_wdata[CTRL_AUTO_BIT]) ? ST_AUTO : ST_MANUAL);
  endproperty
  a_auto_select: assert property (p_auto_select) else $error("auto bit did not select timing mode");

  property p_auto_finish;
    ce && state == ST_AUTO && auto_finish && !ctrl_write |=> op_done && !nvm_program_control[CTRL_PULSE_BIT] && !hv_enable;
  endproperty
  a_auto_finish: assert property (p_auto_finish) else $error("automatic pulse did not end on time");

  property p_done_clears_bit;
    op_done |-> !nvm_program_control[CTRL_PULSE_BIT] && state == ST_IDLE;
  endproperty
  a_done_clears_bit: assert property (p_done_clears_bit) else $error("pulse bit set after completion");

  property p_write_limit;
    write_count <= MAX_SELECTIVE_WRITES;
  endproperty
  a_write_limit: assert property (p_write_limit) else $error("selective write count over limit");

  property p_refuse_no_pulse;
    write_refused |-> !hv_enable && !nvm_program_control[CTRL_PULSE_BIT];
  endproperty
  a_refuse_no_pulse: assert property (p_refuse_no_pulse) else $error("refused write started a pulse");

  property p_manual_hold;
    ce && state == ST_MANUAL && !(ctrl_write && !ctrl_wdata[CTRL_PULSE_BIT]) |=> state == ST_MANUAL && hv_enable;
  endproperty
  a_manual_hold: assert property (p_manual_hold) else $error("manual pulse ended without software");

  property p_freeze;
    !ce |=> $stable(state) && $stable(nvm_program_control);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  c_auto_done: cover property (state == ST_AUTO ##1 op_done);
  c_manual_done: cover property (state == ST_MANUAL ##1 op_done);
  c_refused: cover property (write_refused);
  c_full_count: cover property (write_count == MAX_SELECTIVE_WRITES);
endmodule

// >>> bench/testbench.sv
// Self-checking bench for the EEPROM program/erase timing block.
// Assumes the design holds its own assertions; inputs change on falling edges only.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nvm_timebase_pkg::*;

  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {logic kind; int lo; int hi; logic [7:0] ctrl;} note_type;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [DIV_WIDTH-1:0] shadow_word = '0;
  logic ctrl_write = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic div_high_write = 1'b0;
  logic [DIV_HIGH_WIDTH-1:0] div_high_wdata = '0;
  logic div_low_write = 1'b0;
  logic [DIV_LOW_WIDTH-1:0] div_low_wdata = '0;
  logic [ADDR_WIDTH-1:0] target_addr = '0;
  logic [7:0] nvm_program_control;
  logic [DIV_HIGH_WIDTH-1:0] nvm_timebase_div_high;
  logic [DIV_LOW_WIDTH-1:0] nvm_timebase_div_low;
  logic hv_enable;
  logic op_done;
  logic write_refused;
  logic [WCOUNT_WIDTH-1:0] write_count;
  note_type notes[$];
  int cyc = 0;
  int fail_count = 0;
  int checks_done = 0;
  int dv;
  logic [ADDR_WIDTH-1:0] loc;

  eeprom_program_timebase_ctrl i_eeprom_program_timebase_ctrl (
    .core_clk(core_clk), .nrst(nrst), .ce(ce), .shadow_word(shadow_word),
    .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata),
    .div_high_write(div_high_write), .div_high_wdata(div_high_wdata),
    .div_low_write(div_low_write), .div_low_wdata(div_low_wdata),
    .target_addr(target_addr), .nvm_program_control(nvm_program_control),
    .nvm_timebase_div_high(nvm_timebase_div_high), .nvm_timebase_div_low(nvm_timebase_div_low),
    .hv_enable(hv_enable), .op_done(op_done), .write_refused(write_refused), .write_count(write_count)
  );

  // ----------------------------------------------------------------
  // Clock, cycle count, comparison and verdict
  // ----------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watches the pulse outputs and takes the oldest note for each one seen
  always @(negedge core_clk) begin
    note_type n;
    if (op_done === 1'b1 || write_refused === 1'b1) begin
      if (notes.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        n = notes.pop_front();
        check({15'h0, write_refused}, {15'h0, n.kind});
        check({15'h0, op_done}, {15'h0, ~n.kind});
        check({15'h0, cyc >= n.lo && cyc <= n.hi}, 16'h0001);
        check({8'h0, nvm_program_control}, {8'h0, n.ctrl});
      end
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // Window allows up to one divider period of slack where the first tick lands
  task automatic op(input logic [7:0] d, input logic [ADDR_WIDTH-1:0] a, input logic noted,
                    input logic kind, input int lo, input int hi, input logic [7:0] ctrl, input logic hv);
    @(negedge core_clk);
    target_addr = a;
    ctrl_write = 1'b1;
    ctrl_wdata = d;
    if (noted) notes.push_back('{kind, cyc + lo, cyc + hi, ctrl});
    @(negedge core_clk);
    ctrl_write = 1'b0;
    check({15'h0, hv_enable}, {15'h0, hv});
    for (int i = 0; i < 2000 && notes.size() != 0; i++) @(negedge core_clk);
    check(16'(notes.size()), 16'h0000);
  endtask

  task automatic auto_op(input logic erase, input logic [ADDR_WIDTH-1:0] a);
    int t;
    t = erase ? int'(ERASE_TICKS) : int'(PROGRAM_TICKS);
    op(8'h21 | {5'h00, erase, 2'h0}, a, 1'b1, 1'b0, (dv + 1) * t + 1, (dv + 1) * t + 2 + dv,
       {5'h04, erase, 2'h0}, 1'b1);
  endtask

  task automatic set_div(input logic [DIV_WIDTH-1:0] v);
    @(negedge core_clk);
    div_high_write = 1'b1;
    div_high_wdata = v[9:8];
    div_low_write = 1'b1;
    div_low_wdata = v[7:0];
    @(negedge core_clk);
    div_high_write = 1'b0;
    div_low_write = 1'b0;
    check({6'h0, nvm_timebase_div_high, nvm_timebase_div_low}, {6'h0, v});
    dv = int'(v);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h0532));
    shadow_word = DIV_WIDTH'($urandom);
    repeat (20) @(negedge core_clk);
    nrst = 1'b1;
    repeat (2) @(negedge core_clk);
    check({6'h0, nvm_timebase_div_high, nvm_timebase_div_low}, {6'h0, shadow_word});
    check({8'h0, nvm_program_control}, {8'h0, CTRL_RESET});
    $display("test reset load done");
    set_div(10'h3FF);
    set_div(DIV_WIDTH'($urandom));
    $display("test divider write done");
    for (int e = 0; e < 2; e++) begin
      set_div(DIV_WIDTH'($urandom_range(3, 0)));
      auto_op(e[0], ADDR_WIDTH'($urandom));
    end
    $display("test auto timing done");
    loc = ADDR_WIDTH'($urandom);
    op(8'h01, loc, 1'b0, 1'b0, 0, 0, 8'h00, 1'b1);
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      check({15'h0, hv_enable}, 16'h0001);
    end
    // Clock enable low: a software clear must not be taken and nothing may move
    ce = 1'b0;
    ctrl_write = 1'b1;
    ctrl_wdata = 8'h00;
    repeat (4) @(negedge core_clk);
    ctrl_write = 1'b0;
    ce = 1'b1;
    check({15'h0, hv_enable}, 16'h0001);
    check({8'h0, nvm_program_control}, 16'h0001);
    op(8'h00, loc, 1'b1, 1'b0, 1, 1, 8'h00, 1'b0);
    $display("test manual pulse done");
    // Busy automatic pulse: a second start is ignored, a software clear aborts with no done pulse
    op(8'h21, loc + 2'h2, 1'b0, 1'b0, 0, 0, 8'h00, 1'b1);
    op(8'h27, loc + 2'h2, 1'b0, 1'b0, 0, 0, 8'h00, 1'b1);
    check({8'h0, nvm_program_control}, 16'h0021);
    op(8'h20, loc + 2'h2, 1'b0, 1'b0, 0, 0, 8'h00, 1'b0);
    check({8'h0, nvm_program_control}, 16'h0020);
    repeat (140) @(negedge core_clk);
    $display("test auto abort done");
    set_div(10'h000);
    auto_op(1'b1, loc);
    check({12'h0, write_count}, 16'h0000);
    for (int i = 1; i <= 8; i++) begin
      auto_op(1'b0, loc);
      check({12'h0, write_count}, 16'(i));
    end
    op(8'h21, loc, 1'b1, 1'b1, 1, 1, 8'h20, 1'b0);
    check({12'h0, write_count}, 16'h0008);
    auto_op(1'b0, loc + 1'b1);
    check({12'h0, write_count}, 16'h0001);
    auto_op(1'b1, loc);
    check({12'h0, write_count}, 16'h0000);
    $display("test selective writes done");
    give_verdict();
  end

  // Cuts a hang short; the full sequence needs well under 3000 cycles
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule
